/* File: vm_pkg.sv */
// Shared constants and types for the paging mode and address mode control
package vm_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] LIMIT_REG_OFF = 8'h00;
  localparam logic [7:0] STATUS_REG_OFF = 8'h04;

  // Limit register layout
  localparam int LIMIT_W = 24;
  localparam int LIM_STATE_HI = 23;
  localparam int LIM_STATE_LO = 22;
  localparam int LIM_PRIV_BIT = 21;
  localparam int LIM_MODE_BIT = 20;
  localparam logic [23:0] LIMIT_RST = 24'h00_0000;

  // Status register layout
  localparam int ST_USER = 0;
  localparam int ST_EXT = 1;
  localparam int ST_PEND = 2;
  localparam int ST_SAVE20 = 3;
  localparam int ST_LINK20 = 4;
  localparam int ST_XLATE = 5;
  localparam int ST_PSTAT_LO = 8;

  // Operational state codes held in the limit register
  localparam logic [1:0] OPSTATE_COMPAT = 2'b00;
  localparam logic [1:0] OPSTATE_SPLIT = 2'b01;
  localparam logic [1:0] OPSTATE_UNDEF = 2'b10;
  localparam logic [1:0] OPSTATE_EXT = 2'b11;

  // Page status codes
  localparam logic [3:0] PSTAT_RST = 4'h0;
  localparam logic [3:0] PSTAT_EXEC = 4'h1;
  localparam logic [3:0] PSTAT_OPERAND = 4'h2;

  // Address widths
  localparam int PC_W = 20;
  localparam int DIRECT_W = 15;
  localparam int UBL_EA_W = 5;

  // AHB transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  // Class of the instruction completing on instr_done
  typedef enum logic [2:0] {
    OP_OTHER = 3'd0,
    OP_ENTER_USER = 3'd1,
    OP_BRANCH_LINK_U = 3'd2,
    OP_INDIRECT_RETURN = 3'd3,
    OP_EXECUTE_MEMORY = 3'd4
  } op_kind_e;

  // Paging mode state, one-hot
  typedef enum logic [2:0] {
    MODE_MONITOR = 3'b001,
    MODE_PENDING = 3'b010,
    MODE_USER = 3'b100
  } mode_e;

endpackage

/* File: addr_if.sv */
// Signals between the mode controller and the address bias unit
`timescale 1ns/1ps
interface addr_if;
  logic ext;
  logic translate;
  logic mem_start;
  logic [19:0] pc;
  logic [14:0] direct_addr;
  logic direct_std;
  logic ubl_sel;
  logic [4:0] ubl_ea;
  logic [19:0] ea;
  logic [19:0] pc_eff;
  logic [19:0] mem_addr;
  logic mem_xlate;

  modport ctrl (
    output ext, translate, mem_start, pc, direct_addr, direct_std,
    output ubl_sel, ubl_ea, ea,
    input pc_eff, mem_addr, mem_xlate
  );
  modport unit (
    input ext, translate, mem_start, pc, direct_addr, direct_std,
    input ubl_sel, ubl_ea, ea,
    output pc_eff, mem_addr, mem_xlate
  );
endinterface

/* File: addr_unit.sv */
// Program counter masking and direct address biasing unit
`timescale 1ns/1ps
module addr_unit
  import vm_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link to the mode controller
  addr_if.unit a
);

  logic [19:0] pc_eff_d;

  // Upper counter bits are forced clear outside extended addressing
  always_comb begin
    pc_eff_d = a.ext ? a.pc : {4'h0, a.pc[15:0]};
  end

  // Effective counter view, updated every cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a.pc_eff <= 20'h0_0000;
    end else begin
      a.pc_eff <= pc_eff_d;
    end
  end

  // Address and translate flag captured when the memory cycle starts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a.mem_addr <= 20'h0_0000;
      a.mem_xlate <= 1'b0;
    end else if (a.mem_start) begin
      if (a.ubl_sel) begin
        a.mem_addr <= {15'h0000, a.ubl_ea};
      end else if (a.direct_std && a.ext) begin
        a.mem_addr <= {a.pc[19:15], a.direct_addr};
      end else if (a.direct_std) begin
        a.mem_addr <= {4'h0, a.pc[15], a.direct_addr};
      end else begin
        a.mem_addr <= a.ea;
      end
      // Short branch-link address never goes through the map
      a.mem_xlate <= a.translate && !a.ubl_sel;
    end
  end

endmodule

/* File: vm_mode_ctrl.sv */
// Paging mode and addressing mode control with AHB-Lite register access
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module vm_mode_ctrl
  import vm_pkg::*;
#(
  parameter bit VM_PRESENT = 1'b1
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Instruction sequencer
  input wire logic instr_done,
  input wire op_kind_e op_kind,
  input wire logic int_entry,
  input wire logic int_other_active,
  input wire logic int_sole_active,
  input wire logic demand_page,
  input wire logic dp_exec_operand,
  input wire logic save_word_bit20,
  // Address generation
  input wire logic [19:0] pc_in,
  input wire logic [14:0] direct_addr,
  input wire logic direct_std,
  input wire logic ubl_sel,
  input wire logic [4:0] ubl_ea,
  input wire logic [19:0] ea_in,
  input wire logic mem_start,
  // Mode and address results
  output logic user_mode,
  output logic ext_addr,
  output logic ext_indexing,
  output logic translate,
  output logic save_bit20,
  output logic link_bit20,
  output logic [3:0] page_status,
  output logic [19:0] pc_eff,
  output logic [19:0] mem_addr,
  output logic mem_translate
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations
  mode_e mode_q, mode_d;
  logic [23:0] limit_q;
  logic [1:0] opstate;
  logic ext_d;
  logic ext_idx_d;
  logic xlate_d;
  logic is_user;
  logic is_pend;
  logic bus_req;
  logic wr_pend_q;
  logic [7:0] wr_off_q;
  logic [31:0] rd_word;
  addr_if aif ();

  // Extended addressing for a given state code and paging mode
  function automatic logic ext_of(input logic [1:0] st, input logic usr);
    logic r;
    r = 1'b0;
    case (st)
      OPSTATE_COMPAT: r = 1'b0;
      OPSTATE_SPLIT: r = VM_PRESENT ? !usr : 1'b1;
      OPSTATE_EXT: r = 1'b1;
      default: r = 1'b0; // Undefined state falls back to compatibility
    endcase
    return r;
  endfunction

  // Release successor in state one runs extended and translated
  function automatic logic split_release(input logic [1:0] st);
    return (st == OPSTATE_SPLIT) && VM_PRESENT;
  endfunction

  // Only the lowest 256 bytes of the bus window decode to registers
  function automatic logic in_window(input logic [31:0] a);
    return a[31:8] == 24'h00_0000;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Mode state machine
  assign is_user = (mode_q == MODE_USER);
  assign is_pend = (mode_q == MODE_PENDING);
  assign opstate = limit_q[LIM_STATE_HI:LIM_STATE_LO];

  // Interrupt entry outranks any instruction completing in the same cycle
  // Pending counts as monitor, so faults in the release pair record zero
  always_comb begin
    mode_d = mode_q;
    if (int_entry) begin
      mode_d = MODE_MONITOR;
    end else if (instr_done) begin
      case (mode_q)
        MODE_MONITOR: begin
          if (op_kind == OP_ENTER_USER) begin
            mode_d = MODE_PENDING;
          end else if (op_kind == OP_INDIRECT_RETURN) begin
            if (!ext_addr && save_word_bit20) begin
              mode_d = MODE_USER;
            end else if (ext_addr && int_sole_active &&
                         limit_q[LIM_MODE_BIT]) begin
              mode_d = MODE_USER;
            end
          end
        end
        MODE_PENDING: begin
          // Successor finished with its new address computed
          if (op_kind == OP_BRANCH_LINK_U) begin
            mode_d = MODE_MONITOR;
          end else begin
            mode_d = MODE_USER;
          end
        end
        MODE_USER: begin
          if (op_kind == OP_BRANCH_LINK_U) begin
            mode_d = MODE_MONITOR;
          end
        end
        default: mode_d = MODE_MONITOR;
      endcase
    end
  end

  // Paging mode register
  // The only state that holds the paging mode; user_mode mirrors it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= MODE_MONITOR;
    end else begin
      mode_q <= mode_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Addressing mode and translation decisions
  always_comb begin
    ext_d = ext_of(opstate, mode_d == MODE_USER);
    // The successor of a release in state one indexes as extended
    ext_idx_d = ext_d ||
                ((mode_d == MODE_PENDING) && split_release(opstate));
    // Monitor addresses are physical; user addresses other than the short branch-link one go to the map
    xlate_d = (mode_d == MODE_USER) ||
              ((mode_d == MODE_PENDING) && split_release(opstate));
  end

  // Registered paging outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      user_mode <= 1'b0;
      translate <= 1'b0;
    end else begin
      user_mode <= (mode_d == MODE_USER);
      translate <= xlate_d;
    end
  end

  // Registered addressing outputs
  // A limit write reaches these one edge after the register itself
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_addr <= 1'b0;
      ext_indexing <= 1'b0;
    end else begin
      ext_addr <= ext_d;
      ext_indexing <= ext_idx_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Saved mode bits
  // Save word bit carries the mode out to the interrupt save location
  // A fault during the release pair outranks a same-cycle interrupt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      save_bit20 <= 1'b0;
    end else if (demand_page && is_pend && !ext_addr) begin
      save_bit20 <= 1'b0;
    end else if (int_entry && !ext_addr) begin
      save_bit20 <= is_user;
    end
  end

  // Link register bit records where the branch-link came from
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_bit20 <= 1'b0;
    end else if (instr_done && !int_entry &&
                 op_kind == OP_BRANCH_LINK_U) begin
      link_bit20 <= is_user;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Page status
  // The release op and its successor count as execute-memory operands
  // Other faults report the generic operand code unless dp_exec_operand is set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      page_status <= PSTAT_RST;
    end else if (demand_page) begin
      if (is_pend || dp_exec_operand ||
          (instr_done && op_kind == OP_ENTER_USER)) begin
        page_status <= PSTAT_EXEC;
      end else begin
        page_status <= PSTAT_OPERAND;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave
  assign bus_req = hsel && hready && (htrans == HTRANS_NONSEQ);

  // Readback of the limit register and block state
  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      LIMIT_REG_OFF: rd_word = {8'h00, limit_q};
      STATUS_REG_OFF: begin
        rd_word[ST_USER] = is_user;
        rd_word[ST_EXT] = ext_addr;
        rd_word[ST_PEND] = is_pend;
        rd_word[ST_SAVE20] = save_bit20;
        rd_word[ST_LINK20] = link_bit20;
        rd_word[ST_XLATE] = translate;
        rd_word[ST_PSTAT_LO +: 4] = page_status;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Write address phase, applied in the data phase that follows
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_off_q <= 8'h00;
    end else begin
      wr_pend_q <= bus_req && hwrite && in_window(haddr);
      wr_off_q <= haddr[7:0];
    end
  end

  // Read data is captured at the address phase so it stands in the data
  // phase; it reflects state as it was just before that edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_req && !hwrite) begin
      hrdata <= in_window(haddr) ? rd_word : 32'h0000_0000;
    end
  end

  // Zero wait states and no error replies, so both stay at their idle level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Limit register
  // Hardware updates of bit 20 win over a software write in the same cycle
  // Bits 23..22 are stored as written; the code 10 decodes as state zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      limit_q <= LIMIT_RST;
    end else begin
      if (wr_pend_q && wr_off_q == LIMIT_REG_OFF) begin
        limit_q <= hwdata[LIMIT_W-1:0];
      end
      if (demand_page && is_pend && ext_addr) begin
        limit_q[LIM_MODE_BIT] <= 1'b0;
      end else if (int_entry && ext_addr && !int_other_active) begin
        limit_q[LIM_MODE_BIT] <= is_user;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Address bias unit
  // The bias unit registers its results, so these outputs are flop driven
  assign aif.ext = ext_addr;
  assign aif.translate = translate;
  assign aif.mem_start = mem_start;
  assign aif.pc = pc_in;
  assign aif.direct_addr = direct_addr;
  assign aif.direct_std = direct_std;
  assign aif.ubl_sel = ubl_sel;
  assign aif.ubl_ea = ubl_ea;
  assign aif.ea = ea_in;
  assign pc_eff = aif.pc_eff;
  assign mem_addr = aif.mem_addr;
  assign mem_translate = aif.mem_xlate;

  addr_unit u_addr (
    .hclk(hclk),
    .hresetn(hresetn),
    .a(aif.unit)
  );

endmodule

/* File: vm_mode_ctrl_assertions.sv */
// Port-level assertions for the paging and addressing mode controller
`timescale 1ns/1ps
module vm_mode_ctrl_chk
  import vm_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Sequencer events
  input wire logic instr_done,
  input wire op_kind_e op_kind,
  input wire logic int_entry,
  input wire logic demand_page,
  input wire logic dp_exec_operand,
  // Address generation
  input wire logic [19:0] pc_in,
  input wire logic [14:0] direct_addr,
  input wire logic direct_std,
  input wire logic ubl_sel,
  input wire logic [4:0] ubl_ea,
  input wire logic mem_start,
  // Results
  input wire logic user_mode,
  input wire logic ext_addr,
  input wire logic save_bit20,
  input wire logic link_bit20,
  input wire logic [3:0] page_status,
  input wire logic [19:0] pc_eff,
  input wire logic [19:0] mem_addr,
  input wire logic mem_translate
);
  // One clock domain, so clock and reset are given once
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  chk_reset_mode: assert property ($rose(hresetn) |->
    !user_mode && !ext_addr) else $error("mode not cleared by reset");
  chk_user_entry: assert property ($rose(user_mode) |->
    $past(instr_done) && $past(op_kind) != OP_ENTER_USER)
    else $error("user mode entered early");
  chk_link_mode: assert property (instr_done && !int_entry &&
    op_kind == OP_BRANCH_LINK_U |=> !user_mode &&
    link_bit20 == $past(user_mode)) else $error("branch link mode wrong");
  chk_int_monitor: assert property (int_entry |=> !user_mode)
    else $error("interrupt left user mode");
  chk_int_save: assert property (int_entry && !ext_addr |=>
    save_bit20 == $past(user_mode)) else $error("save bit wrong");
  chk_exec_status: assert property (demand_page && dp_exec_operand
    |=> page_status == PSTAT_EXEC) else $error("page status wrong");
  // Mask follows the addressing mode that held when the counter was taken
  chk_pc_width: assert property ($stable(ext_addr) |=> pc_eff ==
    ($past(pc_in) & {{4{$past(ext_addr)}}, 16'hFFFF}))
    else $error("counter width wrong");
  chk_ubl_unmapped: assert property (mem_start && ubl_sel |=>
    mem_addr == {15'h0, $past(ubl_ea)} && !mem_translate)
    else $error("branch link address mapped");
  chk_direct_bias: assert property (mem_start && !ubl_sel &&
    direct_std && !ext_addr |=> mem_addr ==
    {4'h0, $past(pc_in[15]), $past(direct_addr)})
    else $error("direct bias wrong");
endmodule

bind vm_mode_ctrl vm_mode_ctrl_chk chk_i (.hclk, .hresetn, .instr_done,
  .op_kind, .int_entry, .demand_page, .dp_exec_operand, .pc_in,
  .direct_addr, .direct_std, .ubl_sel, .ubl_ea, .mem_start, .user_mode,
  .ext_addr, .save_bit20, .link_bit20, .page_status, .pc_eff, .mem_addr,
  .mem_translate);

/* File: seq_model.sv */
// Instruction sequencer stand-in that issues completion and event pulses
`timescale 1ns/1ps
module seq_model
  import vm_pkg::*;
(
  // Clock
  input wire logic hclk,
  // Event pulses towards the controller
  output logic instr_done,
  output op_kind_e op_kind,
  output logic int_entry,
  output logic demand_page
);
  int gap = 0;

  // Quiet at time zero; op class idles on a value that must be ignored
  initial begin
    instr_done = 1'b0;
    op_kind = OP_EXECUTE_MEMORY;
    int_entry = 1'b0;
    demand_page = 1'b0;
  end

  // Codes 0..4 retire an op, 5 enters an interrupt, 6 raises a fault
  task automatic issue(input int k);
    repeat (gap) @(posedge hclk);
    instr_done <= (k < 5);
    op_kind <= (k < 5) ? op_kind_e'(k) : OP_OTHER;
    int_entry <= (k == 5);
    demand_page <= (k == 6);
    @(posedge hclk);
    instr_done <= 1'b0;
    op_kind <= OP_EXECUTE_MEMORY;
    int_entry <= 1'b0;
    demand_page <= 1'b0;
  endtask
endmodule

/* File: tb_vm_mode_and_address_mode_control.sv */
// Self-checking bench for the paging and addressing mode controller
`timescale 1ns/1ps
module tb_vm_mode_and_address_mode_control;
  import vm_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, mem_start, ubl_sel, direct_std, dp_exec_operand;
  logic int_other_active, int_sole_active, save_word_bit20;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, rnd;
  logic [19:0] pc_in, ea_in, pc_eff, mem_addr;
  logic [14:0] direct_addr;
  logic [4:0] ubl_ea;
  logic [3:0] page_status;
  logic hreadyout, hresp, user_mode, ext_addr, save_bit20, link_bit20;
  logic mem_translate, instr_done, int_entry, demand_page, ext_idx, xlate;
  op_kind_e op_kind;
  logic [23:0] m_lim;
  bit m_user, m_pend, m_save, m_link;
  logic [3:0] m_ps;
  int seed = 75374;
  int n_fail = 0;
  int comparisons = 0;
  int ops[6] = '{0, 1, 2, 3, 5, 6};

  always #10 hclk = ~hclk;

  vm_mode_ctrl uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .instr_done, .op_kind, .int_entry, .int_other_active, .int_sole_active,
    .demand_page, .dp_exec_operand, .save_word_bit20, .pc_in, .direct_addr,
    .direct_std, .ubl_sel, .ubl_ea, .ea_in, .mem_start, .user_mode,
    .ext_addr, .ext_indexing(ext_idx), .translate(xlate), .save_bit20,
    .link_bit20,
    .page_status, .pc_eff, .mem_addr, .mem_translate);

  seq_model sm (.hclk, .instr_done, .op_kind, .int_entry, .demand_page);

  //////////////////////////////////////////////////////////////////////////
  // Reference model of the mode state
  function automatic bit m_ext();
    return m_lim[23:22] == 2'h3 || (m_lim[23:22] == 2'h1 && !m_user);
  endfunction
  function automatic bit m_xl();
    return m_user || (m_pend && m_lim[23:22] == 2'h1);
  endfunction
  function automatic bit m_xi();
    return m_ext() || (m_pend && m_lim[23:22] == 2'h1);
  endfunction

  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  // Single AHB transfer; waits on ready with no assumed latency
  task automatic bus(input bit w, input logic [31:0] a, d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, hresp);
  endtask

  // Compare both registers and the mode port with the model
  task automatic cmp();
    bus(1'b0, 32'h0000_0004, 32'h0);
    chk("status", {20'h0, m_ps, 2'h0, m_xl(), m_link, m_save, m_pend,
      m_ext(), m_user}, rd);
    bus(1'b0, 32'h0000_0000, 32'h0);
    chk("limit", {8'h0, m_lim}, rd);
    chk("user_mode", m_user, user_mode);
    chk("translate", m_xl(), xlate);
    chk("ext_indexing", m_xi(), ext_idx);
  endtask

  task automatic step(input int k);
    bit was, x;
    was = m_user;
    x = m_ext();
    sm.issue(k);
    case (k)
      0: if (m_pend) {m_pend, m_user} = 2'h1;
      1: m_pend = 1'b1;
      2: {m_link, m_user, m_pend} = {was, 2'h0};
      3: if (!m_user && (x ? int_sole_active && m_lim[20] : save_word_bit20))
        m_user = 1'b1;
      5: begin
        if (!x) m_save = was;
        else if (!int_other_active) m_lim[20] = was;
        {m_user, m_pend} = 2'h0;
      end
      default: begin
        m_ps = (m_pend || dp_exec_operand) ? PSTAT_EXEC : PSTAT_OPERAND;
        if (m_pend && x) m_lim[20] = 1'b0;
        else if (m_pend) m_save = 1'b0;
      end
    endcase
    cmp();
  endtask

  // Address path; counter top bits go back to zero so mode edges stay clean
  task automatic addr(input int sel);
    logic [19:0] e;
    rnd = $random(seed);
    pc_in <= rnd[19:0];
    direct_addr <= rnd[31:17];
    ea_in <= ~rnd[19:0];
    ubl_ea <= rnd[4:0];
    ubl_sel <= (sel == 0);
    direct_std <= (sel == 1);
    repeat (2) @(posedge hclk);
    mem_start <= 1'b1;
    @(posedge hclk);
    mem_start <= 1'b0;
    @(posedge hclk);
    e = sel == 0 ? {15'h0, rnd[4:0]} : sel == 2 ? ~rnd[19:0] :
      m_ext() ? {rnd[19:15], rnd[31:17]} : {4'h0, rnd[15], rnd[31:17]};
    chk("mem_addr", e, mem_addr);
    chk("mem_translate", m_xl() && sel != 0, mem_translate);
    chk("pc_eff", m_ext() ? rnd[19:0] : {4'h0, rnd[15:0]}, pc_eff);
    pc_in <= {4'h0, rnd[15:0]};
  endtask

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    {m_lim, m_user, m_pend, m_save, m_link, m_ps} = '0;
    @(posedge hclk);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int k;
    {hsel, hwrite, htrans, hsize, haddr, hwdata, mem_start, ubl_sel} = '0;
    {direct_std, pc_in, ea_in, direct_addr, ubl_ea, int_other_active} = '0;
    {int_sole_active, save_word_bit20, dp_exec_operand} = 3'h1;
    do_reset();
    cmp();
    bus(1'b0, 32'h0000_0008, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, 32'h0000_0100, 32'hFFFF_FFFF);
    bus(1'b1, 32'h0000_0004, 32'hFFFF_FFFF);
    cmp();
    $display("test reset and map done");
    // States three, one, zero; state two is never written
    for (int i = 0; i < 3; i++) begin
      rnd = $random(seed);
      m_lim = {i == 2 ? 2'h0 : 2'h3 >> i, rnd[21:0]};
      bus(1'b1, 32'h0000_0000, {rnd[31:24], m_lim});
      // Derived mode bits follow the limit register one edge later
      @(posedge hclk);
      cmp();
      repeat (14) begin
        rnd = $random(seed);
        {int_other_active, int_sole_active, save_word_bit20} <= rnd[2:0];
        sm.gap = int'(rnd[5:4]);
        k = ops[rnd[10:8] % 6];
        if (k == 1 && m_user) k = 2;
        step(k);
        if (k == 1) step(0);
        addr(int'(rnd[13:12]) % 3);
      end
      $display("test operational state %0d done", m_lim[23:22]);
    end
    // Fault while the release op is pending, in states zero and three
    dp_exec_operand <= 1'b0;
    for (int j = 0; j < 2; j++) begin
      rnd = $random(seed);
      m_lim = {j == 0 ? 2'h0 : 2'h3, 2'h1, rnd[19:0]};
      bus(1'b1, 32'h0000_0000, {8'h00, m_lim});
      @(posedge hclk);
      cmp();
      step(2);
      step(1);
      step(6);
      step(0);
      step(6);
    end
    $display("test fault during release done");
    do_reset();
    cmp();
    $display("test second reset done");
    wrap_up();
  end

  // Whole run needs well under ten thousand cycles; this cuts a hang
  initial begin
    #1_000_000;
    n_fail++;
    wrap_up();
  end
endmodule
